// ==== hw/hmseq_pkg.sv ====
/*
 homing sequencer package: method codes, speed/position widths, motion
 command struct and state encoding.
 assumes a single control clock domain.
*/
package hmseq_pkg;

	localparam int unsigned SPD_W = 16;
	localparam int unsigned POS_W = 32;

	// method selection, two's complement byte
	localparam logic [7:0] METH_IDX_LEFT_NEG = 8'h0E;
	localparam logic [7:0] METH_IDX_NEG      = 8'h21;
	localparam logic [7:0] METH_IDX_POS      = 8'h22;
	localparam logic [7:0] METH_CUR_FB       = 8'h23;
	localparam logic [7:0] METH_CUR_POS      = 8'h25;
	localparam logic [7:0] METH_SET_INDEX    = 8'hFD;
	localparam logic [7:0] METH_GOTO_STORED  = 8'hFA;

	localparam logic [POS_W-1:0] INDEX_REF_RST = 32'h0000_0000;
	localparam logic [SPD_W-1:0] SPEED_RST     = 16'h0000;

	typedef struct packed {
		logic             run;
		logic             dir_neg;
		logic [SPD_W-1:0] speed;
	} hmseq_motion_t;

	typedef struct packed {
		logic [7:0]       method;
		logic [SPD_W-1:0] approach_speed;
		logic [SPD_W-1:0] index_speed;
	} hmseq_cfg_t;

	typedef enum logic [6:0] {
		ST_IDLE     = 7'b0000001,
		ST_SW_FALL  = 7'b0000010,
		ST_TO_LIMIT = 7'b0000100,
		ST_SW_RISE  = 7'b0001000,
		ST_INDEX    = 7'b0010000,
		ST_GOTO     = 7'b0100000,
		ST_DONE     = 7'b1000000
	} hmseq_state_t;

endpackage

// ==== hw/hmseq_edge.sv ====
/*
 hmseq_edge: rising and falling edge detector for one synchronous input.
 assumes the input is already synchronous to ref_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module hmseq_edge (
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	input  wire logic sig_i,
	output logic      rise_o,
	output logic      fall_o
);
	logic sig_q;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sig_q <= 1'b0;
		end else begin
			sig_q <= sig_i;
		end
	end

	assign rise_o = sig_i & ~sig_q;
	assign fall_o = ~sig_i & sig_q;
endmodule
`default_nettype wire

// ==== hw/hmseq_top.sv ====
/*
 hmseq_top: homing method sequencer. drives a motion command (run,
 direction, speed) and a target position request from the selected
 method, watching home switch, negative limit and index pulse.
 assumes all inputs synchronous to ref_clk_i; the motion loop outside
 follows motion_o and reports target arrival on at_target_i.
*/
`timescale 1ns/100ps
`default_nettype none
module hmseq_top
	import hmseq_pkg::*;
(
	input  wire logic             ref_clk_i,
	input  wire logic             nrst_i,
	input  wire logic             homing_start_input_i,
	input  wire hmseq_cfg_t       cfg_i,
	input  wire logic             encoder_usage_abs_i,
	input  wire logic             home_switch_i,
	input  wire logic             negative_overtravel_limit_i,
	input  wire logic             index_pulse_i,
	input  wire logic [POS_W-1:0] position_i,
	input  wire logic             at_target_i,
	output hmseq_motion_t         motion_o,
	output logic                  goto_valid_o,
	output logic [POS_W-1:0]      goto_pos_o,
	output logic                  home_set_o,
	output logic [POS_W-1:0]      home_pos_o,
	output logic                  homing_done_o,
	output logic                  homing_fail_o,
	output logic                  busy_o
);
	hmseq_state_t     state_q;
	hmseq_state_t     state_d;
	hmseq_cfg_t       cfg_q;
	logic [POS_W-1:0] index_ref_q;
	logic             index_ref_vld_q;
	logic             start_q;
	logic             start_p;
	logic             sw_rise;
	logic             sw_fall;
	logic             idx_rise;
	logic             ref_hit;
	logic             idx_hit;
	logic             is_abs;
	logic             cfg_bad;
	logic             is_sw_meth;
	logic             is_idx_meth;
	logic             is_cur_meth;

	hmseq_edge u_sw_edge (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.sig_i     (home_switch_i),
		.rise_o    (sw_rise),
		.fall_o    (sw_fall)
	);

	hmseq_edge u_idx_edge (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.sig_i     (index_pulse_i),
		.rise_o    (idx_rise),
		.fall_o    ()
	);

	// start edge detect
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			start_q <= 1'b0;
		end else begin
			start_q <= homing_start_input_i;
		end
	end
	assign start_p = homing_start_input_i & ~start_q;

	// configuration captured at start, frozen while busy
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_q <= '{method: 8'h00, approach_speed: SPEED_RST,
			           index_speed: SPEED_RST};
		end else if (start_p && !busy_o) begin
			cfg_q <= cfg_i;
		end
	end

	assign is_abs      = (cfg_q.method == METH_SET_INDEX) ||
	                     (cfg_q.method == METH_GOTO_STORED);
	assign cfg_bad     = is_abs && !encoder_usage_abs_i;
	assign is_sw_meth  = cfg_q.method == METH_IDX_LEFT_NEG;
	assign is_idx_meth = (cfg_q.method == METH_IDX_NEG) ||
	                     (cfg_q.method == METH_IDX_POS);
	assign is_cur_meth = (cfg_q.method == METH_CUR_FB) ||
	                     (cfg_q.method == METH_CUR_POS);

	// stored reference replaces the index pulse once valid
	assign ref_hit = index_ref_vld_q && (position_i == index_ref_q);
	assign idx_hit = index_ref_vld_q ? ref_hit : idx_rise;

	// selection of the next step
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				state_d = ST_IDLE;
			end
			ST_SW_FALL: begin
				if (sw_fall) begin
					state_d = ST_INDEX;
				end
			end
			ST_TO_LIMIT: begin
				if (negative_overtravel_limit_i) begin
					state_d = ST_SW_RISE;
				end
			end
			ST_SW_RISE: begin
				if (sw_rise) begin
					state_d = ST_INDEX;
				end
			end
			ST_INDEX: begin
				if (idx_hit) begin
					state_d = ST_DONE;
				end
			end
			ST_GOTO: begin
				if (at_target_i) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				state_d = ST_DONE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// sequencer state register
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= ST_IDLE;
		end else if (start_p && state_q != ST_IDLE &&
		             state_q != ST_DONE) begin
			state_q <= state_q;
		end else if (start_p) begin
			// decode happens from cfg_i directly on the start cycle
			case (cfg_i.method)
				METH_IDX_LEFT_NEG: begin
					if (home_switch_i) begin
						state_q <= ST_SW_FALL;
					end else begin
						state_q <= ST_TO_LIMIT;
					end
				end
				METH_IDX_NEG, METH_IDX_POS: begin
					state_q <= ST_INDEX;
				end
				METH_CUR_FB, METH_CUR_POS, METH_SET_INDEX: begin
					state_q <= ST_DONE;
				end
				METH_GOTO_STORED: begin
					state_q <= ST_GOTO;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end else if (state_q != ST_IDLE && cfg_bad) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// failure flag: raised on bad encoder setting outside idle, not on unknown method
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			homing_fail_o <= 1'b0;
		end else if (start_p && !busy_o) begin
			homing_fail_o <= 1'b0;
		end else if (state_q != ST_IDLE && cfg_bad) begin
			homing_fail_o <= 1'b1;
		end
	end

	// stored index reference
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			index_ref_q     <= INDEX_REF_RST;
			index_ref_vld_q <= 1'b0;
		end else if (state_q == ST_DONE && !homing_done_o &&
		             cfg_q.method == METH_SET_INDEX && !cfg_bad) begin
			index_ref_q     <= position_i;
			index_ref_vld_q <= 1'b1;
		end
	end

	// home capture and done flag
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			homing_done_o <= 1'b0;
			home_set_o    <= 1'b0;
			home_pos_o    <= '0;
		end else begin
			home_set_o <= 1'b0;
			if (start_p) begin
				homing_done_o <= 1'b0;
			end else if (state_q == ST_DONE && !homing_done_o &&
			             !cfg_bad) begin
				homing_done_o <= 1'b1;
				home_set_o    <= cfg_q.method != METH_SET_INDEX;
				home_pos_o    <= position_i;
			end
		end
	end

	// motion command
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			motion_o     <= '{run: 1'b0, dir_neg: 1'b0, speed: SPEED_RST};
			goto_valid_o <= 1'b0;
			goto_pos_o   <= '0;
		end else begin
			motion_o     <= '{run: 1'b0, dir_neg: 1'b0, speed: SPEED_RST};
			goto_valid_o <= 1'b0;
			case (state_d)
				ST_SW_FALL, ST_TO_LIMIT: begin
					motion_o <= '{run: 1'b1, dir_neg: 1'b1,
					              speed: cfg_q.approach_speed};
				end
				ST_SW_RISE: begin
					motion_o <= '{run: 1'b1, dir_neg: 1'b0,
					              speed: cfg_q.approach_speed};
				end
				ST_INDEX: begin
					motion_o <= '{run: 1'b1,
					              dir_neg: cfg_q.method != METH_IDX_POS,
					              speed: cfg_q.index_speed};
				end
				ST_GOTO: begin
					goto_valid_o <= 1'b1;
					goto_pos_o   <= index_ref_q;
					motion_o     <= '{run: 1'b1, dir_neg: 1'b0,
					                  speed: cfg_q.approach_speed};
				end
				default: begin
					motion_o <= '{run: 1'b0, dir_neg: 1'b0,
					              speed: SPEED_RST};
				end
			endcase
		end
	end

	assign busy_o = (state_q != ST_IDLE) && (state_q != ST_DONE);

	a_done_needs_state: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		$rose(homing_done_o) |-> $past(state_q) == ST_DONE)
		else $error("done raised outside done state");

	a_cfg_frozen: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		busy_o && !start_p |=> $stable(cfg_q))
		else $error("config changed while busy");

	a_no_done_on_bad: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		cfg_bad |=> !$rose(homing_done_o))
		else $error("done with bad encoder setting");

	sequence s_idx_found;
		state_q == ST_INDEX && idx_hit;
	endsequence

	a_index_to_done: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		(s_idx_found and (!start_p && !cfg_bad)) |=> state_q == ST_DONE
		##1 homing_done_o)
		else $error("index did not complete homing");

	a_index_speed: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		$past(state_d) == ST_INDEX && $past(state_q) != ST_IDLE
		|-> motion_o.run && motion_o.speed == cfg_q.index_speed)
		else $error("index search speed wrong");

	a_index_dir: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		state_q == ST_INDEX && motion_o.run
		|-> motion_o.dir_neg == (cfg_q.method != METH_IDX_POS))
		else $error("index search direction wrong");

	a_limit_reverse: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		state_q == ST_TO_LIMIT && negative_overtravel_limit_i && !start_p
		&& !cfg_bad |=> state_q == ST_SW_RISE && !motion_o.dir_neg)
		else $error("no reversal at limit");

	a_switch_fall: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		state_q == ST_SW_FALL && sw_fall && !start_p && !cfg_bad
		|=> state_q == ST_INDEX)
		else $error("switch fall missed");

	a_ref_stored: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		$rose(homing_done_o) && cfg_q.method == METH_SET_INDEX
		|-> index_ref_vld_q && index_ref_q == home_pos_o)
		else $error("index reference not stored");

	a_goto_speed: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		goto_valid_o |-> motion_o.speed == cfg_q.approach_speed
		&& goto_pos_o == index_ref_q)
		else $error("goto uses wrong speed or target");

	a_cur_no_move: assert property (@(posedge ref_clk_i)
		disable iff (!nrst_i)
		state_q == ST_DONE |-> !motion_o.run)
		else $error("motion while homed");
endmodule
`default_nettype wire

// ==== sim/hmseq_ctrl_model.sv ====
/*
 motion controller model: starts homing with an edge, times the run.
 assumes the bench asks for a run by a one-cycle go_i pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module hmseq_ctrl_model #(
	parameter int LIMIT = 100
) (
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	input  wire logic go_i,
	input  wire logic done_i,
	input  wire logic fail_i,
	output logic      start_o,
	output logic      timeout_o
);
	int   cnt;
	logic wait_q;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			start_o   <= 1'b0;
			wait_q    <= 1'b0;
			timeout_o <= 1'b0;
			cnt       <= 0;
		end else begin
			start_o <= go_i;
			if (go_i) begin
				wait_q    <= 1'b1;
				timeout_o <= 1'b0;
				cnt       <= 0;
			end else if (wait_q) begin
				if (cnt > 3 && (done_i || fail_i)) begin
					wait_q <= 1'b0;
				end else if (cnt == LIMIT) begin
					timeout_o <= 1'b1;
					wait_q    <= 1'b0;
				end else begin
					cnt <= cnt + 1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/homing_method_sequencer_bench.sv ====
/*
 bench for hmseq_top: method table, then switch, limit and stored cases.
 assumes the controller model makes the start edge.
*/
`timescale 1ns/100ps
`default_nettype none
module homing_method_sequencer_bench;
	import hmseq_pkg::*;
	typedef struct packed {
		logic [7:0] m;
		logic       run;
		logic       dn;
	} hmseq_row_t;
	localparam logic [15:0] APP = 16'h0123;
	localparam logic [15:0] IDX = 16'h0045;
	logic ref_clk_i, nrst_i, go, enc, sw, lim, idx, at_tgt;
	logic goto_v, home_set, done, fail, busy, start, tmo;
	logic [POS_W-1:0] pos, goto_pos, home_pos;
	hmseq_cfg_t       cfg;
	hmseq_motion_t    mot;
	int               fails, tests_run, cyc, i, sets;
	hmseq_row_t rows [4] = '{'{METH_IDX_NEG, 1'b1, 1'b1},
		'{METH_IDX_POS, 1'b1, 1'b0}, '{METH_CUR_FB, 1'b0, 1'b0},
		'{METH_CUR_POS, 1'b0, 1'b0}};

	hmseq_top dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.homing_start_input_i(start), .cfg_i(cfg),
		.encoder_usage_abs_i(enc), .home_switch_i(sw),
		.negative_overtravel_limit_i(lim), .index_pulse_i(idx),
		.position_i(pos), .at_target_i(at_tgt), .motion_o(mot),
		.goto_valid_o(goto_v), .goto_pos_o(goto_pos),
		.home_set_o(home_set), .home_pos_o(home_pos),
		.homing_done_o(done), .homing_fail_o(fail), .busy_o(busy));
	hmseq_ctrl_model ctrl_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.go_i(go), .done_i(done), .fail_i(fail), .start_o(start),
		.timeout_o(tmo));

	task automatic summarize();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic mot_chk(input logic r, input logic d, input logic [15:0] s);
		chk(mot.run, r, "run");
		chk(busy, r, "busy");
		if (r) begin
			chk(mot.dir_neg, d, "dir");
			chk(mot.speed, s, "speed");
		end
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic go_run(input logic [7:0] m);
		@(posedge ref_clk_i);
		cfg.method <= m;
		go <= 1'b1;
		@(posedge ref_clk_i);
		go <= 1'b0;
		cyc_n(4);
	endtask
	task automatic pulse_idx();
		@(posedge ref_clk_i);
		idx <= 1'b1;
		@(posedge ref_clk_i);
		idx <= 1'b0;
	endtask
	task automatic wait_done();
		for (int k = 0; k < 60 && done !== 1'b1; k++)
			@(posedge ref_clk_i);
		chk(done, 1'b1, "no done");
	endtask

	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		cyc = 0;
		sets = 0;
		forever begin
			@(posedge ref_clk_i);
			cyc++;
			if (home_set === 1'b1)
				sets++;
			if (cyc == 20000) begin
				fails++;
				$display("BAD %0t hang", $time);
				summarize();
			end
		end
	end
	initial begin
		{nrst_i, go, sw, lim, idx, at_tgt} = '0;
		enc = 1'b1;
		pos = 32'h0000_0100;
		cfg = '{8'h00, APP, IDX};
		fails = 0;
		tests_run = 0;
		cyc_n(10);
		nrst_i <= 1'b1;
		cyc_n(2);
		chk({done, fail, goto_v, home_set, mot.run}, 0, "reset");
		foreach (rows[r]) begin
			go_run(rows[r].m);
			mot_chk(rows[r].run, rows[r].dn, IDX);
			if (rows[r].run)
				pulse_idx();
			wait_done();
			chk(home_pos, pos, "home pos");
		end
		sw <= 1'b1;
		go_run(METH_IDX_LEFT_NEG);
		mot_chk(1'b1, 1'b1, APP);
		cfg.approach_speed <= 16'h0777;
		cyc_n(3);
		mot_chk(1'b1, 1'b1, APP);
		sw <= 1'b0;
		cfg.approach_speed <= APP;
		cyc_n(4);
		mot_chk(1'b1, 1'b1, IDX);
		pulse_idx();
		wait_done();
		go_run(METH_IDX_LEFT_NEG);
		mot_chk(1'b1, 1'b1, APP);
		lim <= 1'b1;
		cyc_n(4);
		mot_chk(1'b1, 1'b0, APP);
		lim <= 1'b0;
		sw <= 1'b1;
		cyc_n(4);
		mot_chk(1'b1, 1'b1, IDX);
		pulse_idx();
		wait_done();
		sw <= 1'b0;
		go_run(8'h05);
		for (i = 0; i < 300 && tmo !== 1'b1; i++)
			@(posedge ref_clk_i);
		chk(tmo, 1'b1, "no timeout");
		chk({done, fail}, 0, "unknown method");
		enc <= 1'b0;
		go_run(METH_GOTO_STORED);
		chk({done, fail}, 2'b01, "encoder usage");
		enc <= 1'b1;
		pos <= 32'h0000_1234;
		go_run(METH_SET_INDEX);
		wait_done();
		pos <= 32'h0000_0010;
		go_run(METH_IDX_NEG);
		mot_chk(1'b1, 1'b1, IDX);
		pos <= 32'h0000_1234;
		wait_done();
		chk(home_pos, 32'h0000_1234, "stored ref");
		pos <= 32'h0000_0500;
		go_run(METH_GOTO_STORED);
		chk(goto_v, 1'b1, "goto valid");
		chk(goto_pos, 32'h0000_1234, "goto target");
		mot_chk(1'b1, 1'b0, APP);
		at_tgt <= 1'b1;
		wait_done();
		at_tgt <= 1'b0;
		cyc_n(2);
		chk(sets, 8, "home set pulses");
		nrst_i <= 1'b0;
		cyc_n(2);
		chk({done, fail, goto_v, home_set, mot.run}, 0, "mid reset");
		nrst_i <= 1'b1;
		cyc_n(2);
		chk(busy, 1'b0, "busy after reset");
		summarize();
	end
endmodule
`default_nettype wire
